// [rtl/usb_irq_wrap.sv]
// usb wrapper interrupt masking, end of interrupt and receive aggregation registers

module usb_irq_wrap (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [24:0] i_raw_src,
	input wire logic i_core_irq_direct_mode,
	input wire logic [3:0] i_agg_mode,
	input wire usb_irq_pkg::rx_pkt_type i_rx_pkt,
	output logic [24:0] o_irq_mask,
	output usb_irq_pkg::agg_done_type o_agg_done,
	output logic o_irq_req,
	output logic o_irq
);
	logic [24:0] mask_q;
	logic [24:0] mask_d;
	logic [7:0] eoi_q;
	logic [16:0] size_q [usb_irq_pkg::NUM_EP];
	logic [31:0] rdata_d;
	logic masked_any_q;
	logic [24:0] masked;
	logic [24:0] live_src;
	logic masked_any;
	logic wr_set;
	logic wr_clr;
	logic wr_eoi;
	logic wr_evt_clr;
	logic wr_evt_mask;
	logic eoi_ack;
	logic irq_req_d;
	logic [3:0] wr_size;
	logic [3:0] ep_done;
	logic [16:0] ep_total [usb_irq_pkg::NUM_EP];
	logic [3:0] evt_status;
	logic [3:0] evt_mask;
	logic evt_irq;
	logic [1:0] done_ep;
	logic [16:0] done_bytes;

	// write decode
	assign wr_set = i_wr && (i_addr == usb_irq_pkg::OFS_MASK_ENABLE);
	assign wr_clr = i_wr && (i_addr == usb_irq_pkg::OFS_MASK_DISABLE);
	assign wr_eoi = i_wr && (i_addr == usb_irq_pkg::OFS_EOI_ACK);
	assign wr_evt_clr = i_wr && (i_addr == usb_irq_pkg::OFS_EVT_STATUS);
	assign wr_evt_mask = i_wr && (i_addr == usb_irq_pkg::OFS_EVT_MASK);
	assign wr_size[0] = i_wr && (i_addr == usb_irq_pkg::OFS_EP1_AGG);
	assign wr_size[1] = i_wr && (i_addr == usb_irq_pkg::OFS_EP2_AGG);
	assign wr_size[2] = i_wr && (i_addr == usb_irq_pkg::OFS_EP3_AGG);
	assign wr_size[3] = i_wr && (i_addr == usb_irq_pkg::OFS_EP4_AGG);
	// only a zero vector counts as service done
	assign eoi_ack = wr_eoi && (i_wdata[7:0] == usb_irq_pkg::EOI_ACK_VALUE);

	// one shared mask, set and clear ports act only on defined bits
	assign mask_d = (wr_set ? (mask_q | (i_wdata[24:0] & usb_irq_pkg::SRC_VALID))
		: wr_clr ? (mask_q & ~i_wdata[24:0]) : mask_q) & usb_irq_pkg::SRC_VALID;

	// in direct mode the endpoint bits belong to the core, keep only the core field
	assign live_src = i_core_irq_direct_mode
		? (i_raw_src & {{usb_irq_pkg::CORE_W{1'b1}}, 16'h0000}) : i_raw_src;
	assign masked = live_src & mask_q & usb_irq_pkg::SRC_VALID;
	assign masked_any = |masked;

	// request on a fresh pending source, or again after service while still pending
	assign irq_req_d = masked_any && (!masked_any_q || eoi_ack);

	// read data, reserved and unmapped bits read as zero
	assign rdata_d = !i_rd ? 32'h00000000
		: (i_addr == usb_irq_pkg::OFS_MASK_ENABLE) ? {7'h00, mask_q}
		: (i_addr == usb_irq_pkg::OFS_MASK_DISABLE) ? {7'h00, mask_q}
		: (i_addr == usb_irq_pkg::OFS_MASKED_STATUS) ? {7'h00, masked}
		: (i_addr == usb_irq_pkg::OFS_EOI_ACK) ? {24'h000000, eoi_q}
		: (i_addr == usb_irq_pkg::OFS_EP1_AGG) ? {15'h0000, size_q[0]}
		: (i_addr == usb_irq_pkg::OFS_EP2_AGG) ? {15'h0000, size_q[1]}
		: (i_addr == usb_irq_pkg::OFS_EP3_AGG) ? {15'h0000, size_q[2]}
		: (i_addr == usb_irq_pkg::OFS_EP4_AGG) ? {15'h0000, size_q[3]}
		: (i_addr == usb_irq_pkg::OFS_EVT_STATUS) ? {28'h0000000, evt_status}
		: (i_addr == usb_irq_pkg::OFS_EVT_MASK) ? {28'h0000000, evt_mask}
		: 32'h00000000;

	// mask, vector and request flops
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			mask_q <= usb_irq_pkg::MASK_RESET;
			eoi_q <= usb_irq_pkg::EOI_RESET;
			masked_any_q <= 1'b0;
			o_irq_req <= 1'b0;
			o_rdata <= 32'h00000000;
			o_irq <= 1'b0;
		end
		else
		begin
			mask_q <= mask_d;
			eoi_q <= wr_eoi ? i_wdata[7:0] : eoi_q;
			masked_any_q <= masked_any;
			o_irq_req <= irq_req_d;
			o_rdata <= rdata_d;
			o_irq <= masked_any || evt_irq;
		end
	end

	assign o_irq_mask = mask_q;

	// per endpoint size register and accumulator
	generate
		for (genvar e = 0; e < usb_irq_pkg::NUM_EP; e++)
		begin : g_ep
			logic hit;

			assign hit = i_rx_pkt.valid && (i_rx_pkt.ep == 2'(e));

			// full 17 bits kept so 65536 itself is accepted
			always_ff @(posedge i_clk)
			begin
				if (!i_rst_b)
					size_q[e] <= usb_irq_pkg::SIZE_RESET;
				else if (wr_size[e])
					size_q[e] <= i_wdata[16:0];
			end

			agg_counter #(
				.SIZE_W(usb_irq_pkg::SIZE_W),
				.BYTE_W(usb_irq_pkg::PKT_BYTES_W)
			) u_agg (
				.i_clk(i_clk),
				.i_rst_b(i_rst_b),
				.i_en(i_agg_mode[e]),
				.i_limit(size_q[e]),
				.i_pkt_valid(hit),
				.i_bytes(i_rx_pkt.bytes),
				.i_short(i_rx_pkt.short_pkt),
				.o_done(ep_done[e]),
				.o_total(ep_total[e])
			);
		end
	endgenerate

	// one packet per cycle, so at most one endpoint closes at a time
	assign done_ep = ep_done[3] ? 2'h3 : ep_done[2] ? 2'h2 : ep_done[1] ? 2'h1 : 2'h0;
	assign done_bytes = ep_total[done_ep];

	// closed packet descriptor to the dma side
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			o_agg_done <= '0;
		else
		begin
			o_agg_done.valid <= |ep_done;
			o_agg_done.ep <= done_ep;
			o_agg_done.bytes <= done_bytes;
		end
	end

	evt_irq #(
		.W(usb_irq_pkg::NUM_EP)
	) u_evt (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_set(ep_done),
		.i_clr_wr(wr_evt_clr),
		.i_mask_wr(wr_evt_mask),
		.i_wdata(i_wdata[3:0]),
		.o_status(evt_status),
		.o_mask(evt_mask),
		.o_irq(evt_irq)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_eoi_pending;
		eoi_ack && masked_any;
	endsequence

	mask_clear_a: assert property (wr_clr |=> mask_q == ($past(mask_q) & ~$past(i_wdata[24:0])))
		else $error("mask disable write did not clear exactly the written bits");
	mask_ep_only_a: assert property (wr_clr && i_wdata[24:0] == 25'h0000002 |=>
		(mask_q ^ $past(mask_q)) == ($past(mask_q) & 25'h0000002))
		else $error("endpoint mask clear touched another bit");
	mask_set_a: assert property (wr_set |=>
		mask_q == (($past(mask_q) | $past(i_wdata[24:0])) & usb_irq_pkg::SRC_VALID))
		else $error("mask enable write did not set the written bits");
	mask_readback_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_MASK_DISABLE && !i_wr
		|=> o_rdata == {7'h00, $past(mask_q)} && mask_q == $past(mask_q))
		else $error("mask disable read wrong or had a side effect");
	masked_view_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_MASKED_STATUS
		|=> o_rdata[24:0] == $past(masked) && o_rdata[31:25] == 7'h00)
		else $error("masked status read does not match source and mask");
	eoi_store_a: assert property (wr_eoi ##1 (i_rd && i_addr == usb_irq_pkg::OFS_EOI_ACK)
		|=> o_rdata == {24'h000000, $past(i_wdata[7:0], 2)})
		else $error("end of interrupt vector not held");
	eoi_rerequest_a: assert property (s_eoi_pending |=> o_irq_req)
		else $error("no new request after service with a pending source");
	size_reserved_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_EP1_AGG
		|=> o_rdata[31:17] == 15'h0000 && o_rdata[16:0] == $past(size_q[0]))
		else $error("size register read wrong or reserved bits set");
	size_max_a: assert property (wr_size[1] && i_wdata[16:0] == usb_irq_pkg::SIZE_MAX
		|=> size_q[1] == usb_irq_pkg::SIZE_MAX)
		else $error("largest legal size not accepted");
	size_read4_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_EP4_AGG
		|=> o_rdata == {15'h0000, $past(size_q[3])})
		else $error("last size register read wrong");

	// read data stands for one cycle only, so a late sampler sees zero, not stale data
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h00000000)
		else $error("read data outside the cycle after a read");
	rdata_unmapped_a: assert property (i_rd && i_addr > usb_irq_pkg::OFS_EVT_MASK
		|=> o_rdata == 32'h00000000)
		else $error("unmapped address read nonzero");

	// the shared mask moves only on a set or clear write; reads never touch it
	mask_hold_a: assert property (!wr_set && !wr_clr |=> mask_q == $past(mask_q))
		else $error("mask changed without a set or clear write");
	core_clear_a: assert property (wr_clr && i_wdata[24:16] != 9'h000
		|=> (mask_q[24:16] & $past(i_wdata[24:16])) == 9'h000)
		else $error("core field mask bit survived a clear");
	enable_readback_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_MASK_ENABLE
		|=> o_rdata == {7'h00, $past(mask_q)})
		else $error("mask enable read does not show the shared mask");

	// masked view rebuilt from the inputs rather than from the internal product
	masked_live_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_MASKED_STATUS
		&& !i_core_irq_direct_mode
		|=> o_rdata[24:0] == ($past(i_raw_src) & $past(mask_q) & usb_irq_pkg::SRC_VALID))
		else $error("masked status differs from source and mask");
	direct_core_only_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_MASKED_STATUS
		&& i_core_irq_direct_mode |=> o_rdata[15:0] == 16'h0000)
		else $error("endpoint bits shown in direct mode");

	// the vector keeps the last written value, nonzero or not
	eoi_write_a: assert property (wr_eoi |=> eoi_q == $past(i_wdata[7:0]))
		else $error("end of interrupt vector not stored");
	eoi_hold_a: assert property (!wr_eoi |=> eoi_q == $past(eoi_q))
		else $error("end of interrupt vector changed without a write");

	// a nonzero vector is only stored, so a source already seen must not raise a second request
	sequence s_eoi_nonzero;
		wr_eoi && i_wdata[7:0] != usb_irq_pkg::EOI_ACK_VALUE;
	endsequence
	sequence s_fresh_pending;
		masked_any && !masked_any_q;
	endsequence
	eoi_quiet_a: assert property (s_eoi_nonzero ##0 masked_any_q |=> !o_irq_req)
		else $error("nonzero vector raised a request");
	fresh_req_a: assert property (s_fresh_pending |=> o_irq_req)
		else $error("new pending source raised no request");
	req_cause_a: assert property (o_irq_req |-> $past(masked_any))
		else $error("request without a pending masked source");
	irq_line_a: assert property (o_irq == ($past(masked_any) || $past(evt_irq)))
		else $error("interrupt line does not follow pending sources");

	// closes land exactly two cycles after the packet that caused them
	sequence s_short_taken;
		i_rx_pkt.valid && i_rx_pkt.short_pkt && i_agg_mode[i_rx_pkt.ep];
	endsequence
	sequence s_pkt_refused;
		i_rx_pkt.valid && !i_agg_mode[i_rx_pkt.ep];
	endsequence
	short_done_a: assert property (s_short_taken |-> ##2 o_agg_done.valid
		&& o_agg_done.ep == $past(i_rx_pkt.ep, 2))
		else $error("short packet gave no closed aggregate");
	refused_pkt_a: assert property (s_pkt_refused |-> ##2 !o_agg_done.valid)
		else $error("disabled endpoint closed an aggregate");

	// a closed aggregate always leaves its sticky event behind, a clear cannot race it
	done_status_a: assert property (o_agg_done.valid
		|-> (evt_status & (4'h1 << o_agg_done.ep)) != 4'h0)
		else $error("closed aggregate left no event");
	evt_read_a: assert property (i_rd && i_addr == usb_irq_pkg::OFS_EVT_STATUS
		|=> o_rdata == {28'h0000000, $past(evt_status)})
		else $error("event status read wrong");

	// each size register keeps all 17 written bits, 65536 included
	generate
		for (genvar s = 0; s < usb_irq_pkg::NUM_EP; s++)
		begin : g_size_chk
			size_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
				wr_size[s] |=> size_q[s] == $past(i_wdata[16:0]))
				else $error("size register did not keep the written count");
		end
	endgenerate
endmodule // usb_irq_wrap

// [inc/usb_irq_pkg.sv]
// constants and carrier types for the usb wrapper interrupt and aggregation block
package usb_irq_pkg;
	// register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	// register byte offsets
	localparam logic [7:0] OFS_MASK_ENABLE = 8'h00;
	localparam logic [7:0] OFS_MASK_DISABLE = 8'h04;
	localparam logic [7:0] OFS_MASKED_STATUS = 8'h08;
	localparam logic [7:0] OFS_EOI_ACK = 8'h0c;
	localparam logic [7:0] OFS_EP1_AGG = 8'h10;
	localparam logic [7:0] OFS_EP2_AGG = 8'h14;
	localparam logic [7:0] OFS_EP3_AGG = 8'h18;
	localparam logic [7:0] OFS_EP4_AGG = 8'h1c;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h20;
	localparam logic [7:0] OFS_EVT_MASK = 8'h24;
	// interrupt source / mask layout
	localparam int unsigned SRC_W = 25;
	localparam int unsigned CTRL_EP_BIT = 0;
	localparam int unsigned TX_EP_LSB = 1;
	localparam int unsigned RX_EP_LSB = 9;
	localparam int unsigned CORE_LSB = 16;
	localparam int unsigned CORE_W = 9;
	localparam logic [24:0] SRC_VALID = 25'h1ff1e1f;
	localparam logic [24:0] MASK_RESET = 25'h0000000;
	// end of interrupt vector
	localparam int unsigned EOI_W = 8;
	localparam logic [7:0] EOI_RESET = 8'h00;
	localparam logic [7:0] EOI_ACK_VALUE = 8'h00;
	// aggregation
	localparam int unsigned NUM_EP = 4;
	localparam int unsigned SIZE_W = 17;
	localparam int unsigned PKT_BYTES_W = 11;
	localparam logic [16:0] SIZE_RESET = 17'h00000;
	localparam logic [16:0] SIZE_MAX = 17'h10000;
	localparam logic [3:0] EVT_MASK_RESET = 4'h0;
	// one received usb packet, endpoint index 0 means endpoint 1
	typedef struct packed {
		logic valid;
		logic [1:0] ep;
		logic short_pkt;
		logic [10:0] bytes;
	} rx_pkt_type;
	// one closed aggregate packet handed to the dma side
	typedef struct packed {
		logic valid;
		logic [1:0] ep;
		logic [16:0] bytes;
	} agg_done_type;
endpackage

// [rtl/agg_counter.sv]
// byte accumulator that closes one aggregate packet for one receive endpoint
module agg_counter #(
	parameter int unsigned SIZE_W = 17,
	parameter int unsigned BYTE_W = 11
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_en,
	input wire logic [SIZE_W-1:0] i_limit,
	input wire logic i_pkt_valid,
	input wire logic [BYTE_W-1:0] i_bytes,
	input wire logic i_short,
	output logic o_done,
	output logic [SIZE_W-1:0] o_total
);
	logic [SIZE_W-1:0] count_q;
	logic [SIZE_W-1:0] count_d;
	logic [SIZE_W:0] sum;
	logic reach;
	logic close;

	// wide sum so a full limit plus a packet cannot wrap
	assign sum = {1'b0, count_q} + {{(SIZE_W+1-BYTE_W){1'b0}}, i_bytes};
	// a zero limit only closes on short packets
	assign reach = (i_limit != '0) && (sum >= {1'b0, i_limit});
	assign close = i_en && i_pkt_valid && (i_short || reach);
	assign count_d = !i_en ? '0 : close ? '0 : i_pkt_valid ? sum[SIZE_W-1:0] : count_q;

	// accumulate, close on limit or short packet
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			count_q <= '0;
			o_done <= 1'b0;
			o_total <= '0;
		end
		else
		begin
			count_q <= count_d;
			o_done <= close;
			o_total <= close ? sum[SIZE_W-1:0] : o_total;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	short_close_a: assert property (i_en && i_pkt_valid && i_short |=> o_done)
		else $error("short packet did not close the aggregate");
	limit_close_a: assert property (o_done && !$past(i_short) |-> o_total >= $past(i_limit))
		else $error("aggregate closed before reaching the limit");
endmodule // agg_counter

// [rtl/evt_irq.sv]
// sticky event status with write-one-to-clear, mask and one level interrupt
module evt_irq #(
	parameter int unsigned W = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_set,
	input wire logic i_clr_wr,
	input wire logic i_mask_wr,
	input wire logic [W-1:0] i_wdata,
	output logic [W-1:0] o_status,
	output logic [W-1:0] o_mask,
	output logic o_irq
);
	logic [W-1:0] status_d;

	// set wins over a clear in the same cycle
	assign status_d = (o_status & ~({W{i_clr_wr}} & i_wdata)) | i_set;

	// status, mask and level output
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_status <= '0;
			o_mask <= '0;
			o_irq <= 1'b0;
		end
		else
		begin
			o_status <= status_d;
			o_mask <= i_mask_wr ? i_wdata : o_mask;
			o_irq <= |(status_d & (i_mask_wr ? i_wdata : o_mask));
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	set_wins_a: assert property (|i_set |=> (o_status & $past(i_set)) == $past(i_set))
		else $error("event lost against a clear");
	irq_level_a: assert property (o_irq == |(o_status & o_mask))
		else $error("event interrupt does not follow status and mask");
endmodule // evt_irq

// [dv/usb_irq_wrap_tb_top.sv]
// self-checking bench for the usb wrapper interrupt and aggregation registers
module usb_irq_wrap_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk;
	logic i_rst_b;
	logic [7:0] i_addr;
	logic [31:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [31:0] o_rdata;
	logic [24:0] i_raw_src;
	logic i_core_irq_direct_mode;
	logic [3:0] i_agg_mode;
	usb_irq_pkg::rx_pkt_type i_rx_pkt;
	logic [24:0] o_irq_mask;
	usb_irq_pkg::agg_done_type o_agg_done;
	logic o_irq_req;
	logic o_irq;
	logic [31:0] exp_q[$];
	logic [31:0] agg_q[$];
	logic [31:0] n_errors = 0;
	logic [31:0] checks_done = 0;
	logic [31:0] n_req = 0;
	logic [31:0] n0;
	logic [31:0] seed = 68375;
	logic [31:0] exp;
	logic [31:0] m;
	logic rd_seen = 1'b0;

	usb_irq_wrap u_usb_irq_wrap (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_raw_src(i_raw_src),
		.i_core_irq_direct_mode(i_core_irq_direct_mode), .i_agg_mode(i_agg_mode),
		.i_rx_pkt(i_rx_pkt), .o_irq_mask(o_irq_mask), .o_agg_done(o_agg_done),
		.o_irq_req(o_irq_req), .o_irq(o_irq));

	// free running 20 mhz clock
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done = checks_done + 1;
		if (seen !== want)
		begin
			n_errors = n_errors + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one idle cycle after each strobe keeps every signal to one assignment per edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask

	// write then read back with no gap between the two strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		exp_q.push_back(e);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic pkt(input logic [1:0] e, input logic s, input logic [10:0] b);
		i_rx_pkt <= {1'b1, e, s, b};
		@(posedge i_clk);
		i_rx_pkt <= '0;
		@(posedge i_clk);
	endtask

	// read data stands only in the cycle after the strobe, so it is taken at that edge
	always @(posedge i_clk)
	begin
		if (rd_seen)
			check(o_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hdeadbeef);
		if (o_agg_done.valid === 1'b1)
			check(32'({o_agg_done.ep, o_agg_done.bytes}),
				agg_q.size() > 0 ? agg_q.pop_front() : 32'hdeadbeef);
		if (o_irq_req === 1'b1)
			n_req <= n_req + 32'h1;
		rd_seen <= i_rd;
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge i_clk);
		n_errors = n_errors + 1;
		summarize();
	end

	initial
	begin
		i_rst_b = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_raw_src = '0;
		i_core_irq_direct_mode = 1'b0;
		i_agg_mode = 4'h0;
		i_rx_pkt = '0;
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		// every place reads zero after reset, unmapped ones too
		for (int a = 0; a <= 'h30; a += 4)
			rd(8'(a), 32'h0);
		$display("test reset done");
		// set all, then clear one bit at a time, reserved bits included
		wr(usb_irq_pkg::OFS_MASK_ENABLE, 32'hffffffff);
		exp = 32'(usb_irq_pkg::SRC_VALID);
		rd(usb_irq_pkg::OFS_MASK_ENABLE, exp);
		rd(usb_irq_pkg::OFS_MASK_DISABLE, exp);
		rd(usb_irq_pkg::OFS_MASK_DISABLE, exp);
		for (int i = 0; i < 32; i++)
		begin
			wr(usb_irq_pkg::OFS_MASK_DISABLE, 32'h1 << i);
			exp = exp & ~(32'h1 << i);
			rd(usb_irq_pkg::OFS_MASK_DISABLE, exp);
			check(32'(o_irq_mask), exp);
		end
		$display("test mask done");
		// random sources and masks in both modes; the masked view ignores writes
		for (int k = 0; k < 6; k++)
		begin
			seed = lfsr(seed);
			m = seed;
			seed = lfsr(seed);
			wr(usb_irq_pkg::OFS_MASK_DISABLE, 32'hffffffff);
			wr(usb_irq_pkg::OFS_MASK_ENABLE, m);
			i_raw_src <= seed[24:0];
			i_core_irq_direct_mode <= k[0];
			exp = seed & m & 32'(usb_irq_pkg::SRC_VALID) & (k[0] ? 32'h01ff0000 : 32'hffffffff);
			wr(usb_irq_pkg::OFS_MASKED_STATUS, 32'hffffffff);
			rd(usb_irq_pkg::OFS_MASKED_STATUS, exp);
			check(32'(o_irq), 32'(exp != 0));
		end
		$display("test masked done");
		// only a zero vector acknowledges; a pending source then raises a new request
		i_core_irq_direct_mode <= 1'b0;
		i_raw_src <= '0;
		wr(usb_irq_pkg::OFS_MASK_ENABLE, 32'h1);
		repeat (3) @(posedge i_clk);
		n0 = n_req;
		i_raw_src <= 25'h1;
		repeat (4) @(posedge i_clk);
		check(n_req, n0 + 32'h1);
		n0 = n_req;
		wr_rd(usb_irq_pkg::OFS_EOI_ACK, 32'hffffff5a, 32'h5a);
		check(n_req, n0);
		wr_rd(usb_irq_pkg::OFS_EOI_ACK, 32'h0, 32'h0);
		check(n_req, n0 + 32'h1);
		i_raw_src <= '0;
		repeat (3) @(posedge i_clk);
		n0 = n_req;
		wr(usb_irq_pkg::OFS_EOI_ACK, 32'h0);
		rd(usb_irq_pkg::OFS_EOI_ACK, 32'h0);
		check(n_req, n0);
		$display("test ack done");
		// size registers keep 17 bits, the largest legal value included
		for (int e = 0; e < 4; e++)
		begin
			seed = lfsr(seed);
			wr(usb_irq_pkg::OFS_EP1_AGG + 8'(4 * e), seed);
			rd(usb_irq_pkg::OFS_EP1_AGG + 8'(4 * e), seed & 32'h1ffff);
		end
		wr(usb_irq_pkg::OFS_EP4_AGG, 32'h10000);
		rd(usb_irq_pkg::OFS_EP4_AGG, 32'h10000);
		// each endpoint closes exactly at its limit, limits a multiple of 64
		i_agg_mode <= 4'hf;
		for (int e = 0; e < 4; e++)
		begin
			wr(usb_irq_pkg::OFS_EP1_AGG + 8'(4 * e), 32'(64 * (e + 1)));
			agg_q.push_back({13'h0, 2'(e), 17'(64 * (e + 1))});
			repeat (e + 1) pkt(2'(e), 1'b0, 11'd64);
		end
		// a short packet closes early under the largest limit
		wr(usb_irq_pkg::OFS_EP2_AGG, 32'h10000);
		agg_q.push_back({13'h0, 2'd1, 17'd612});
		pkt(2'd1, 1'b0, 11'd512);
		pkt(2'd1, 1'b1, 11'd100);
		// a disabled endpoint counts nothing, so the next close carries only its own bytes
		i_agg_mode <= 4'hb;
		pkt(2'd2, 1'b0, 11'd64);
		pkt(2'd2, 1'b1, 11'd64);
		i_agg_mode <= 4'hf;
		agg_q.push_back({13'h0, 2'd2, 17'd10});
		pkt(2'd2, 1'b1, 11'd10);
		repeat (4) @(posedge i_clk);
		check(32'(agg_q.size()), 32'h0);
		$display("test aggregation done");
		// close events: sticky, masked into the interrupt line, cleared by writing ones
		rd(usb_irq_pkg::OFS_EVT_STATUS, 32'hf);
		check(32'(o_irq), 32'h0);
		wr(usb_irq_pkg::OFS_EVT_MASK, 32'h1);
		rd(usb_irq_pkg::OFS_EVT_MASK, 32'h1);
		check(32'(o_irq), 32'h1);
		wr(usb_irq_pkg::OFS_EVT_STATUS, 32'he);
		rd(usb_irq_pkg::OFS_EVT_STATUS, 32'h1);
		check(32'(o_irq), 32'h1);
		wr(usb_irq_pkg::OFS_EVT_STATUS, 32'h1);
		rd(usb_irq_pkg::OFS_EVT_STATUS, 32'h0);
		check(32'(o_irq), 32'h0);
		$display("test events done");
		summarize();
	end
endmodule // usb_irq_wrap_tb_top
